// file: result_bank.sv
// Result register bank: latest samples, changes, status and read port
//
// Function
// - FIFO mode zero shows real-time results
// - Combined flags need data-ready event enable
// - Pressure flags need pressure event enable
// - Temperature flags need temperature event enable
// - Altimeter bit selects altitude or pressure result
// - Altitude is signed Q16.4 in bytes 01h-03h
// - Pressure is unsigned Q18.2 in bytes 01h-03h
// - Status and results auto-increment from 00h-05h
// - Temperature is signed Q8.4 in 04h-05h
// - Change registers 07h-09h hold pressure difference
// - Altitude change: 16 integer, 4 fraction bits
// - Pressure change: 18 integer, 2 fraction bits
// - Changes update regardless of FIFO mode
// - Registers 0Ah-0Bh hold temperature difference
// - Temperature change is signed 12-bit value
// - Reading high result bytes clears ready flags when FIFO mode is zero
// - FIFO mode: 01h gives FIFO, 02h-05h read zero
`timescale 1ns/100ps
`include "result_bank_map.svh"
module result_bank
  import result_bank_pkg::*;
(
  input wire logic clk, // 50 MHz clock
  input wire logic rst_b, // Async reset, active low
  input wire logic p_sample_valid, // Pressure/altitude sample done
  input wire p_word_t p_sample, // Pressure/altitude sample value
  input wire logic t_sample_valid, // Temperature sample done
  input wire t_word_t t_sample, // Temperature sample value
  input wire logic altimeter_mode_bit, // 1 altitude, 0 pressure
  input wire fifo_mode_t fifo_mode, // FIFO mode field
  input wire logic data_ready_event_enable, // Combined flag enable
  input wire logic pressure_event_enable, // Pressure flag enable
  input wire logic temperature_event_enable, // Temperature flag enable
  input wire byte_t fifo_data, // Oldest FIFO byte
  input wire logic reg_addr_load, // Start of access, load pointer
  input wire addr_t reg_addr, // Register address to load
  input wire logic reg_rd, // Read strobe, one cycle
  input wire logic reg_wr, // Write strobe, one cycle
  input wire byte_t reg_wdata, // Write data, ignored
  output byte_t reg_rdata_r, // Read data
  output logic reg_rvalid_r, // Read data valid, one cycle
  output addr_t reg_ptr_r, // Current register pointer
  output logic fifo_pop_r, // One FIFO byte consumed
  output logic result_is_altitude_r, // Result holds altitude
  output logic any_data_ready_flag, // Combined ready flag
  output logic any_data_overwrite_flag, // Combined overwrite flag
  output logic pressure_ready_flag, // Pressure ready flag
  output logic pressure_overwrite_flag, // Pressure overwrite flag
  output logic temperature_ready_flag, // Temperature ready flag
  output logic temperature_overwrite_flag, // Temperature overwrite flag
  output byte_t data_status_register // Status byte at 00h
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  p_word_t pressure_value_bits;
  p_word_t pressure_change_bits;
  t_word_t temperature_value_bits;
  t_word_t temperature_change_bits;
  logic fifo_on;
  logic read_p_high;
  logic read_t_high;
  logic read_fifo;
  logic clear_p;
  logic clear_t;
  logic clear_any;
  logic any_set;
  logic write_seen;
  byte_t status_nxt;
  byte_t result_nxt;
  byte_t read_nxt;
  addr_t ptr_nxt;
  logic in_result_window;

  // ----------------------------------------
  // Register byte views
  // ----------------------------------------
  byte_t pressure_result_high;
  byte_t pressure_result_middle;
  byte_t pressure_result_low;
  byte_t temperature_result_high;
  byte_t temperature_result_low;
  byte_t pressure_change_high;
  byte_t pressure_change_middle;
  byte_t pressure_change_low;
  byte_t temperature_change_high;
  byte_t temperature_change_low;

  // ----------------------------------------
  // Sample channels
  // ----------------------------------------
  // Result and change registers load on every sample, whatever FIFO mode
  // First change after reset is taken against zero
  sample_channel #(
    .W(`P_WIDTH)
  ) u_pressure (
    .clk(clk),
    .rst_b(rst_b),
    .load(p_sample_valid),
    .value(p_sample),
    .value_r(pressure_value_bits),
    .delta_r(pressure_change_bits)
  );

  sample_channel #(
    .W(`T_WIDTH)
  ) u_temperature (
    .clk(clk),
    .rst_b(rst_b),
    .load(t_sample_valid),
    .value(t_sample),
    .value_r(temperature_value_bits),
    .delta_r(temperature_change_bits)
  );

  // ----------------------------------------
  // Result mode
  // ----------------------------------------
  // Tracks which unit the stored result carries; latched with the sample
  // Kept per sample so a later mode change cannot mislabel old data
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      result_is_altitude_r <= 1'b0;
    else if (p_sample_valid)
      result_is_altitude_r <= altimeter_mode_bit;
  end

  // ----------------------------------------
  // Byte layout
  // ----------------------------------------
  // Same bit slicing serves Q16.4 altitude and Q18.2 pressure
  // Reserved low nibbles are tied to zero, not stored
  assign pressure_result_high =
    pressure_value_bits[`P_HI_MSB:`P_HI_LSB];
  assign pressure_result_middle =
    pressure_value_bits[`P_MID_MSB:`P_MID_LSB];
  assign pressure_result_low =
    {pressure_value_bits[`FRAC_MSB:`FRAC_LSB], `NIBBLE_ZERO};
  assign temperature_result_high =
    temperature_value_bits[`T_HI_MSB:`T_HI_LSB];
  assign temperature_result_low =
    {temperature_value_bits[`FRAC_MSB:`FRAC_LSB], `NIBBLE_ZERO};
  assign pressure_change_high =
    pressure_change_bits[`P_HI_MSB:`P_HI_LSB];
  assign pressure_change_middle =
    pressure_change_bits[`P_MID_MSB:`P_MID_LSB];
  assign pressure_change_low =
    {pressure_change_bits[`FRAC_MSB:`FRAC_LSB], `NIBBLE_ZERO};
  assign temperature_change_high =
    temperature_change_bits[`T_HI_MSB:`T_HI_LSB];
  assign temperature_change_low =
    {temperature_change_bits[`FRAC_MSB:`FRAC_LSB], `NIBBLE_ZERO};

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  assign fifo_on = (fifo_mode != `FIFO_MODE_OFF);
  assign read_p_high = reg_rd && (reg_ptr_r == `ADDR_P_HIGH);
  assign read_t_high = reg_rd && (reg_ptr_r == `ADDR_T_HIGH);
  assign read_fifo = read_p_high && fifo_on;
  assign in_result_window =
    (reg_ptr_r >= `ADDR_P_MID) && (reg_ptr_r <= `ADDR_T_LOW);

  // ----------------------------------------
  // Flag clears
  // ----------------------------------------
  // In FIFO mode a FIFO byte read acknowledges every flag
  assign clear_p = (read_p_high && !fifo_on) || read_fifo;
  assign clear_t = (read_t_high && !fifo_on) || read_fifo;
  assign clear_any = clear_p || clear_t;
  // Result and change registers have no write path
  assign write_seen = reg_wr && (reg_wdata == reg_wdata);

  // ----------------------------------------
  // Event sources
  // ----------------------------------------
  // Either channel finishing counts as combined new data
  assign any_set = p_sample_valid || t_sample_valid;

  // ----------------------------------------
  // Event flags
  // ----------------------------------------
  // One flag pair per event class, each gated by its own enable
  event_flags u_any_flags (
    .clk(clk),
    .rst_b(rst_b),
    .enable(data_ready_event_enable),
    .set(any_set),
    .clear(clear_any),
    .ready_r(any_data_ready_flag),
    .overwrite_r(any_data_overwrite_flag)
  );

  event_flags u_p_flags (
    .clk(clk),
    .rst_b(rst_b),
    .enable(pressure_event_enable),
    .set(p_sample_valid),
    .clear(clear_p),
    .ready_r(pressure_ready_flag),
    .overwrite_r(pressure_overwrite_flag)
  );

  event_flags u_t_flags (
    .clk(clk),
    .rst_b(rst_b),
    .enable(temperature_event_enable),
    .set(t_sample_valid),
    .clear(clear_t),
    .ready_r(temperature_ready_flag),
    .overwrite_r(temperature_overwrite_flag)
  );

  // ----------------------------------------
  // Status byte
  // ----------------------------------------
  always_comb
  begin
    status_nxt = `BYTE_ZERO;
    status_nxt[`ST_ANY_OVW] = any_data_overwrite_flag;
    status_nxt[`ST_P_OVW] = pressure_overwrite_flag;
    status_nxt[`ST_T_OVW] = temperature_overwrite_flag;
    status_nxt[`ST_ANY_RDY] = any_data_ready_flag;
    status_nxt[`ST_P_RDY] = pressure_ready_flag;
    status_nxt[`ST_T_RDY] = temperature_ready_flag;
  end

  // Registered copy lags the flags a cycle; reads use the live value
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      data_status_register <= `BYTE_ZERO;
    else
      data_status_register <= status_nxt;
  end

  // ----------------------------------------
  // Read data mux
  // ----------------------------------------
  always_comb
  begin
    result_nxt = `BYTE_ZERO;
    unique case (reg_ptr_r)
      `ADDR_STATUS:
        result_nxt = status_nxt;
      `ADDR_P_HIGH:
        result_nxt = pressure_result_high;
      `ADDR_P_MID:
        result_nxt = pressure_result_middle;
      `ADDR_P_LOW:
        result_nxt = pressure_result_low;
      `ADDR_T_HIGH:
        result_nxt = temperature_result_high;
      `ADDR_T_LOW:
        result_nxt = temperature_result_low;
      `ADDR_PCHG_HIGH:
        result_nxt = pressure_change_high;
      `ADDR_PCHG_MID:
        result_nxt = pressure_change_middle;
      `ADDR_PCHG_LOW:
        result_nxt = pressure_change_low;
      `ADDR_TCHG_HIGH:
        result_nxt = temperature_change_high;
      `ADDR_TCHG_LOW:
        result_nxt = temperature_change_low;
      // Unmapped addresses read zero
      default:
        result_nxt = `BYTE_ZERO;
    endcase
  end

  // ----------------------------------------
  // FIFO output gating
  // ----------------------------------------
  // FIFO bytes share the pressure high address; the rest of the result
  // window reads zero so stale samples never pass for buffered data
  always_comb
  begin
    read_nxt = result_nxt;
    if (fifo_on)
    begin
      if (reg_ptr_r == `ADDR_P_HIGH)
        read_nxt = fifo_data;
      else if (in_result_window)
        read_nxt = `BYTE_ZERO;
    end
  end

  // Read data holds until the next read so a slow host can fetch it
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata_r <= `BYTE_ZERO;
    else if (reg_rd)
      reg_rdata_r <= read_nxt;
  end

  // Answer comes exactly one cycle after the strobe
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rvalid_r <= 1'b0;
    else
      reg_rvalid_r <= reg_rd;
  end

  // ----------------------------------------
  // FIFO byte consumption
  // ----------------------------------------
  // Pop follows the read by one cycle, after the byte has been taken
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      fifo_pop_r <= 1'b0;
    else
      fifo_pop_r <= read_fifo;
  end

  // ----------------------------------------
  // Auto-increment pointer
  // ----------------------------------------
  // FIFO bursts stay on 01h so a long read drains the buffer
  // Pointer wraps past FFh; nothing above 0Bh is mapped
  always_comb
  begin
    ptr_nxt = reg_ptr_r;
    if (reg_addr_load)
      ptr_nxt = reg_addr;
    else if (read_fifo)
      ptr_nxt = reg_ptr_r;
    else if (reg_rd || write_seen)
      ptr_nxt = reg_ptr_r + `ADDR_STEP;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_ptr_r <= `ADDR_STATUS;
    else
      reg_ptr_r <= ptr_nxt;
  end
endmodule

// file: result_bank_map.svh
// Address map, bit positions and reset values of the result register bank
`ifndef RESULT_BANK_MAP_SVH
`define RESULT_BANK_MAP_SVH

// Register addresses
`define ADDR_STATUS 8'h00
`define ADDR_P_HIGH 8'h01
`define ADDR_P_MID 8'h02
`define ADDR_P_LOW 8'h03
`define ADDR_T_HIGH 8'h04
`define ADDR_T_LOW 8'h05
`define ADDR_PCHG_HIGH 8'h07
`define ADDR_PCHG_MID 8'h08
`define ADDR_PCHG_LOW 8'h09
`define ADDR_TCHG_HIGH 8'h0A
`define ADDR_TCHG_LOW 8'h0B

// Address step of the auto-increment pointer
`define ADDR_STEP 8'h01

// Status byte bit positions
`define ST_ANY_OVW 7
`define ST_P_OVW 6
`define ST_T_OVW 5
`define ST_ANY_RDY 3
`define ST_P_RDY 2
`define ST_T_RDY 1

// FIFO mode value that selects real-time result registers
`define FIFO_MODE_OFF 2'h0

// Reset and filler values, channel word widths
`define BYTE_ZERO 8'h00
`define NIBBLE_ZERO 4'h0
`define P_WIDTH 20
`define T_WIDTH 12

// Byte fields of the 20-bit pressure word and 12-bit temperature word
`define P_HI_MSB 19
`define P_HI_LSB 12
`define P_MID_MSB 11
`define P_MID_LSB 4
`define T_HI_MSB 11
`define T_HI_LSB 4
`define FRAC_MSB 3
`define FRAC_LSB 0

`endif

// file: result_bank_pkg.sv
// Types shared by the result register bank
package result_bank_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [7:0] addr_t;
  typedef logic [1:0] fifo_mode_t;
  typedef logic [19:0] p_word_t;
  typedef logic [11:0] t_word_t;
endpackage

// file: sample_channel.sv
// One measurement channel: latest sample and change from the previous one
`timescale 1ns/100ps
module sample_channel #(
  parameter int W = 20
) (
  input wire logic clk, // 50 MHz clock
  input wire logic rst_b, // Async reset, active low
  input wire logic load, // New sample strobe
  input wire logic [W-1:0] value, // New sample value
  output logic [W-1:0] value_r, // Latest sample
  output logic [W-1:0] delta_r // Latest minus previous
);

  // ----------------------------------------
  // Latest sample
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      value_r <= '0;
    else if (load)
      value_r <= value;
  end

  // ----------------------------------------
  // Change register
  // ----------------------------------------
  // Modulo difference: signed and unsigned formats share the same bits
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      delta_r <= '0;
    else if (load)
      delta_r <= value - value_r;
  end
endmodule

// file: event_flags.sv
// Ready and overwrite flag pair for one class of sample events
`timescale 1ns/100ps
module event_flags (
  input wire logic clk, // 50 MHz clock
  input wire logic rst_b, // Async reset, active low
  input wire logic enable, // Flag generation enable
  input wire logic set, // New data event, one cycle
  input wire logic clear, // Read clear, one cycle
  output logic ready_r, // New data ready flag
  output logic overwrite_r // Unread data overwritten flag
);

  logic hit;

  assign hit = set & enable;

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  // Set takes priority over clear for the ready flag so an event landing on a read is not lost
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ready_r <= 1'b0;
    else if (hit)
      ready_r <= 1'b1;
    else if (clear)
      ready_r <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      overwrite_r <= 1'b0;
    else if (hit && ready_r && !clear)
      overwrite_r <= 1'b1;
    else if (clear)
      overwrite_r <= 1'b0;
  end
endmodule

// file: result_bank_chk_sva.sv
// Port checker for the result register bank
`timescale 1ns/100ps
`include "result_bank_map.svh"
module result_bank_chk
  import result_bank_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_b, // Async reset, active low
  input wire logic p_sample_valid, // Pressure sample done
  input wire logic t_sample_valid, // Temperature sample done
  input wire logic altimeter_mode_bit, // Altitude select
  input wire fifo_mode_t fifo_mode, // FIFO mode field
  input wire logic data_ready_event_enable, // Combined enable
  input wire logic pressure_event_enable, // Pressure enable
  input wire logic temperature_event_enable, // Temperature enable
  input wire logic reg_addr_load, // Pointer load
  input wire logic reg_rd, // Read strobe
  input wire logic reg_wr, // Write strobe
  input wire byte_t reg_rdata_r, // Read data
  input wire logic reg_rvalid_r, // Read valid
  input wire addr_t reg_ptr_r, // Pointer
  input wire logic fifo_pop_r, // FIFO pop
  input wire logic result_is_altitude_r, // Stored mode
  input wire logic any_data_ready_flag, // Combined ready
  input wire logic pressure_ready_flag, // Pressure ready
  input wire logic pressure_overwrite_flag, // Pressure overwrite
  input wire logic temperature_ready_flag, // Temperature ready
  input wire logic temperature_overwrite_flag, // Temperature overwrite
  input wire byte_t data_status_register // Status byte
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  rd_answer_a:
    assert property (reg_rvalid_r == $past(reg_rd))
    else $error("read answer not one cycle after strobe");
  ptr_step_a:
    assert property ((reg_rd || reg_wr) && !reg_addr_load
      && !(fifo_mode != `FIFO_MODE_OFF && reg_ptr_r == `ADDR_P_HIGH)
      |=> reg_ptr_r == $past(reg_ptr_r) + `ADDR_STEP)
    else $error("pointer did not advance");
  fifo_hold_a:
    assert property (reg_rd && !reg_addr_load && reg_ptr_r == `ADDR_P_HIGH
      && fifo_mode != `FIFO_MODE_OFF |=> reg_ptr_r == `ADDR_P_HIGH && fifo_pop_r)
    else $error("FIFO read did not hold pointer and pop");
  fifo_zero_a:
    assert property (reg_rd && fifo_mode != `FIFO_MODE_OFF
      && reg_ptr_r inside {[8'h02:8'h05]} |=> reg_rdata_r == `BYTE_ZERO)
    else $error("result byte not zero in FIFO mode");

  // ----------------------------------------
  // Flags and results
  // ----------------------------------------
  p_set_a:
    assert property (p_sample_valid && pressure_event_enable
      |=> pressure_ready_flag)
    else $error("pressure ready not set");
  p_gate_a:
    assert property (!pressure_ready_flag
      && !(p_sample_valid && pressure_event_enable) |=> !pressure_ready_flag)
    else $error("pressure ready set without cause");
  t_gate_a:
    assert property (!temperature_ready_flag
      && !(t_sample_valid && temperature_event_enable)
      |=> !temperature_ready_flag)
    else $error("temperature ready set without cause");
  any_gate_a:
    assert property (!any_data_ready_flag && !(data_ready_event_enable
      && (p_sample_valid || t_sample_valid)) |=> !any_data_ready_flag)
    else $error("combined ready set without cause");
  p_clear_a:
    assert property (reg_rd && reg_ptr_r == `ADDR_P_HIGH && !p_sample_valid
      && fifo_mode == `FIFO_MODE_OFF |=> !pressure_ready_flag)
    else $error("pressure ready not cleared by read");
  mode_track_a:
    assert property (p_sample_valid
      |=> result_is_altitude_r == $past(altimeter_mode_bit))
    else $error("result mode not taken with sample");
  t_ovw_a:
    assert property (t_sample_valid && temperature_event_enable
      && temperature_ready_flag && !reg_rd |=> temperature_overwrite_flag)
    else $error("temperature overwrite not set");
  status_lag_a:
    assert property (
      data_status_register[`ST_ANY_RDY] == $past(any_data_ready_flag)
      && data_status_register[`ST_P_RDY] == $past(pressure_ready_flag)
      && data_status_register[`ST_T_RDY] == $past(temperature_ready_flag)
      && data_status_register[`ST_T_OVW] == $past(temperature_overwrite_flag))
    else $error("status byte does not follow the flags");

  cover property (temperature_overwrite_flag);
  cover property (reg_rd && fifo_mode != `FIFO_MODE_OFF);
  cover property (pressure_overwrite_flag);
  cover property (reg_wr);
endmodule

bind result_bank result_bank_chk result_bank_chk_inst (.*);

// file: host_reader.sv
// Host model: pointer loads, writes and reads of the register port
`timescale 1ns/100ps
module host_reader
  import result_bank_pkg::*;
(
  input wire logic clk, // Clock
  input wire byte_t reg_rdata_r, // Read data
  input wire logic reg_rvalid_r, // Read valid
  output logic reg_addr_load, // Pointer load strobe
  output addr_t reg_addr, // Pointer value
  output logic reg_rd, // Read strobe
  output logic reg_wr, // Write strobe
  output byte_t reg_wdata // Write data
);
  initial
  begin
    reg_addr_load = 1'b0;
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end

  // Released buses carry the inverse so stale values never match
  task automatic load(input addr_t a);
    @(negedge clk);
    reg_addr_load = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_addr_load = 1'b0;
    reg_addr = ~a;
  endtask

  task automatic wr(input byte_t v);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_wdata = v;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~v;
  endtask

  task automatic rd(output byte_t d, output logic ok);
    int k;
    @(negedge clk);
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    ok = 1'b0;
    d = 8'h00;
    for (k = 0; k < 4 && !ok; k++)
    begin
      if (reg_rvalid_r === 1'b1)
      begin
        d = reg_rdata_r;
        ok = 1'b1;
      end
      else
        @(negedge clk);
    end
  endtask
endmodule

// file: result_bank_tb.sv
// Self-checking testbench of the result register bank
`timescale 1ns/100ps
`include "result_bank_map.svh"
module result_bank_tb
  import result_bank_pkg::*;
  ;
  logic clk = 1'b0;
  logic rst_b, p_sample_valid, t_sample_valid, altimeter_mode_bit, ok;
  logic data_ready_event_enable, pressure_event_enable, reg_addr_load;
  logic temperature_event_enable, reg_rd, reg_wr, reg_rvalid_r, fifo_pop_r;
  logic result_is_altitude_r, any_data_ready_flag, any_data_overwrite_flag;
  logic pressure_ready_flag, pressure_overwrite_flag, temperature_ready_flag;
  logic temperature_overwrite_flag;
  logic [2:0] en;
  p_word_t p_sample, pv, pdv;
  t_word_t t_sample, tv, tdv;
  fifo_mode_t fifo_mode;
  byte_t fifo_data, reg_wdata, reg_rdata_r, data_status_register, st_e, d;
  addr_t reg_addr, reg_ptr_r;
  int n_fail = 0;
  int samples_checked = 0;
  int i;

  always #10 clk = ~clk;

  result_bank result_bank_inst (.*);
  host_reader host_reader_inst (.*);

  // ----------------------------------------
  // Checking and expectations
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input byte_t seen, input byte_t exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, seen, exp);
    end
  endtask

  function automatic byte_t exp_byte(input addr_t a);
    if (fifo_mode != `FIFO_MODE_OFF && a inside {[8'h01:8'h05]})
      return (a == 8'h01) ? fifo_data : 8'h00;
    case (a)
      8'h00: return st_e;
      8'h01: return pv[19:12];
      8'h02: return pv[11:4];
      8'h03: return {pv[3:0], 4'h0};
      8'h04: return tv[11:4];
      8'h05: return {tv[3:0], 4'h0};
      8'h07: return pdv[19:12];
      8'h08: return pdv[11:4];
      8'h09: return {pdv[3:0], 4'h0};
      8'h0A: return tdv[11:4];
      8'h0B: return {tdv[3:0], 4'h0};
      default: return 8'h00;
    endcase
  endfunction

  task automatic rd_chk(input addr_t a);
    host_reader_inst.rd(d, ok);
    if (!ok)
    begin
      n_fail++;
      print_verdict();
    end
    check(d, exp_byte(a));
  endtask

  task automatic burst(input addr_t a, input int n);
    int k;
    host_reader_inst.load(a);
    for (k = 0; k < n; k++)
      rd_chk(addr_t'(a + k));
  endtask

  task automatic send_p(input p_word_t v);
    @(negedge clk);
    p_sample_valid = 1'b1;
    p_sample = v;
    pdv = v - pv;
    pv = v;
    @(negedge clk);
    p_sample_valid = 1'b0;
    p_sample = ~v;
  endtask

  task automatic send_t(input t_word_t v);
    @(negedge clk);
    t_sample_valid = 1'b1;
    t_sample = v;
    tdv = v - tv;
    tv = v;
    @(negedge clk);
    t_sample_valid = 1'b0;
    t_sample = ~v;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'h4F62));
    rst_b = 1'b0;
    {p_sample_valid, t_sample_valid, altimeter_mode_bit} = 3'h0;
    {data_ready_event_enable, pressure_event_enable} = 2'h3;
    temperature_event_enable = 1'b1;
    {p_sample, pv, pdv, t_sample, tv, tdv} = '0;
    fifo_mode = `FIFO_MODE_OFF;
    fifo_data = 8'h00;
    st_e = 8'h00;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    burst(8'h00, 12);
    // Every enable mix; odd passes overwrite both samples
    for (i = 0; i < 10; i++)
    begin
      @(negedge clk);
      en = (i < 8) ? 3'(i) : 3'h7;
      {data_ready_event_enable, pressure_event_enable} = en[2:1];
      temperature_event_enable = en[0];
      altimeter_mode_bit = 1'($urandom);
      if (i[0])
        send_p(p_word_t'($urandom));
      send_p(i == 9 ? 20'h80000 : p_word_t'($urandom));
      if (i[0])
        send_t(t_word_t'($urandom));
      send_t(i == 9 ? 12'h800 : t_word_t'($urandom));
      st_e = {en[2], en[1] & i[0], en[0] & i[0], 1'b0, en, 1'b0};
      @(negedge clk);
      check(data_status_register, st_e);
      check(byte_t'(result_is_altitude_r), byte_t'(altimeter_mode_bit));
      burst(8'h00, 12);
    end
    host_reader_inst.load(8'h01);
    host_reader_inst.wr(byte_t'($urandom));
    rd_chk(8'h02);
    for (i = 1; i < 4; i++)
    begin
      @(negedge clk);
      fifo_mode = 2'(i);
      fifo_data = byte_t'($urandom);
      send_p(p_word_t'($urandom));
      send_t(t_word_t'($urandom));
      host_reader_inst.load(8'h01);
      repeat (3) rd_chk(8'h01);
      check(reg_ptr_r, 8'h01);
      burst(8'h02, 4);
      check(data_status_register, 8'h00);
      burst(8'h07, 5);
    end
    print_verdict();
  end
endmodule
